// File: qrs_defs.svh
// Constants for the quadrature and revolution sensor input block
`ifndef QRS_DEFS_SVH
`define QRS_DEFS_SVH

`define QRS_CLK_HZ          100000000
`define QRS_PHASE_MAX_HZ    200000
`define QRS_EDGES_PER_CYCLE 4
`define QRS_CNT_MAX_RATE    800000
// Speed sampling window: 100 ms, so counts per window times 600 gives counts per minute
`define QRS_WINDOW_MS       100
`define QRS_WINDOW_CYCLES   ((`QRS_CLK_HZ / 1000) * `QRS_WINDOW_MS)
`define QRS_WINDOWS_PER_MIN (60000 / `QRS_WINDOW_MS)
`define QRS_CPR_RESET       32'h00000400
`define QRS_POS_RESET       32'h00000000

`endif

// File: qrs_pkg.sv
// Types for the quadrature and revolution sensor input block
package qrs_pkg;

    typedef enum logic { QRS_USE_PRIMARY, QRS_USE_SLIP_CHECK } qrs_use_t;

    typedef enum logic [1:0] { QRS_SPD_IDLE, QRS_SPD_DIVIDE, QRS_SPD_DONE } qrs_spd_state_t;

endpackage

// File: qrs_step_if.sv
// Decoded step events passed from the edge decoder to the top
`timescale 1ns/1ps
interface qrs_step_if;
    logic step;
    logic up;
    logic fault;
    modport dec (output step, output up, output fault);
    modport top (input step, input up, input fault);
endinterface

// File: qrs_quad_dec.sv
// Synchroniser and four-edge quadrature decoder
`timescale 1ns/1ps
module qrs_quad_dec
(
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    input  wire logic  i_phase_first,
    input  wire logic  i_phase_second,
    qrs_step_if.dec    step_if
);
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] prev;
    logic [1:0] cur;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync_a <= 2'h3;
            sync_b <= 2'h3;
        end
        else
        begin
            sync_a <= {sync_a[0], i_phase_first};
            sync_b <= {sync_b[0], i_phase_second};
        end
    end

    assign cur = {sync_a[1], sync_b[1]};

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            prev <= 2'h3;
        else
            prev <= cur;
    end

    // ------------------------------------------------------------
    // Decode: an edge of one phase alone is one count; edges of both phases at once are a fault, not a count
    // ------------------------------------------------------------
    // At 100 MHz a 200 kHz phase gives 125 cycles between edges, so one
    // sample per clock never misses a transition.
    always_comb
    begin
        step_if.step  = 1'b0;
        step_if.up    = 1'b0;
        step_if.fault = 1'b0;
        unique case ({prev, cur})
            4'b0001, 4'b0111, 4'b1110, 4'b1000:
            begin
                step_if.step = 1'b1;
                step_if.up   = 1'b1;
            end
            4'b0010, 4'b1011, 4'b1101, 4'b0100:
                step_if.step = 1'b1;
            4'b0011, 4'b1100, 4'b0110, 4'b1001:
                step_if.fault = 1'b1;
            default:
                step_if.step = 1'b0;
        endcase
    end
endmodule

// File: qrs_top.sv
// Quadrature encoder and revolution sensor input block
`timescale 1ns/1ps
// Operation
// - Decode in four-edge mode: four counts per phase period.
// - Count correctly with phases up to 200 kHz, 800,000 counts/s.
// - Encoder use selectable: primary position source or slip check only.
// - Primary mode reports position as accumulated count, in counts.
// - Primary mode computes speed in rev/min from count rate and counts per rev.
// - Default: low level on revolution input means active.
// - Inversion setting makes high level active.
// - Idle-high disconnected sensor is inactive with default polarity, no event.
`include "qrs_defs.svh"
module qrs_top
#(
    parameter int unsigned WINDOW_CYCLES = `QRS_WINDOW_CYCLES,
    parameter int unsigned POS_W         = 32
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_phase_first,
    input  wire logic              i_phase_second,
    input  wire logic              i_rev_sensor,
    input  wire logic              i_rev_invert,
    input  wire logic              i_use_slip_check,
    input  wire logic              i_pos_clear,
    input  wire logic [31:0]       i_counts_per_revolution,
    output logic [POS_W-1:0]       o_position,
    output logic [POS_W-1:0]       o_slip_count,
    output logic signed [31:0]     o_revolutions_per_minute,
    output logic                   o_speed_valid,
    output logic                   o_rev_active,
    output logic                   o_rev_event,
    output logic                   o_phase_fault
);
    qrs_step_if step_if ();

    qrs_quad_dec u_dec
    (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_phase_first  (i_phase_first),
        .i_phase_second (i_phase_second),
        .step_if        (step_if)
    );

    qrs_pkg::qrs_use_t       use_mode;
    qrs_pkg::qrs_spd_state_t spd_state;
    logic [31:0]             win_cnt;
    logic signed [31:0]      win_delta;
    logic [31:0]             dividend;
    logic [31:0]             divisor;
    logic [31:0]             quotient;
    logic [5:0]              div_bit;
    logic                    neg;
    logic [1:0]              rev_sync;
    logic                    rev_prev;
    logic                    rev_level;
    logic [POS_W-1:0]        next_count;
    logic [32:0]             rem_trial;
    logic [31:0]             rem;

    assign use_mode = i_use_slip_check ? qrs_pkg::QRS_USE_SLIP_CHECK
                                       : qrs_pkg::QRS_USE_PRIMARY;

    // ------------------------------------------------------------
    // Position accumulators
    // ------------------------------------------------------------
    always_comb
    begin
        next_count = '0;
        if (step_if.up)
            next_count = POS_W'(1);
        else
            next_count = {POS_W{1'b1}};
    end

    // Primary mode counts into the position; slip-check mode counts into
    // a separate register so the reported position is left untouched.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_position <= '0;
        else if (i_pos_clear)
            o_position <= '0;
        else if (step_if.step && use_mode == qrs_pkg::QRS_USE_PRIMARY)
            o_position <= o_position + next_count;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_slip_count <= '0;
        else if (i_pos_clear)
            o_slip_count <= '0;
        else if (step_if.step && use_mode == qrs_pkg::QRS_USE_SLIP_CHECK)
            o_slip_count <= o_slip_count + next_count;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_phase_fault <= 1'b0;
        else
            o_phase_fault <= step_if.fault;
    end

    // ------------------------------------------------------------
    // Speed window
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            win_cnt   <= '0;
            win_delta <= '0;
        end
        else if (win_cnt == WINDOW_CYCLES - 1)
        begin
            win_cnt <= '0;
            // A step in the closing cycle opens the next window, so none is lost
            if (step_if.step)
                win_delta <= step_if.up ? 32'sh1 : -32'sh1;
            else
                win_delta <= '0;
        end
        else
        begin
            win_cnt <= win_cnt + 32'h1;
            if (step_if.step)
                win_delta <= step_if.up ? win_delta + 32'sh1 : win_delta - 32'sh1;
        end
    end

    // ------------------------------------------------------------
    // Speed divider: speed = window counts * windows per minute / counts per rev
    // ------------------------------------------------------------
    // Restoring divider, one bit per clock: 33 cycles per result, far
    // shorter than the window, so no result is ever skipped.
    assign rem_trial = {rem, dividend[31]} - {1'b0, divisor};

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            spd_state <= qrs_pkg::QRS_SPD_IDLE;
            dividend  <= '0;
            divisor   <= '0;
            quotient  <= '0;
            rem       <= '0;
            div_bit   <= '0;
            neg       <= 1'b0;
        end
        else
        begin
            unique case (spd_state)
                qrs_pkg::QRS_SPD_IDLE:
                    if (win_cnt == WINDOW_CYCLES - 1 && use_mode == qrs_pkg::QRS_USE_PRIMARY)
                    begin
                        neg       <= win_delta[31];
                        dividend  <= 32'((win_delta[31] ? -win_delta : win_delta)
                                         * `QRS_WINDOWS_PER_MIN);
                        divisor   <= (i_counts_per_revolution == '0)
                                     ? 32'h1 : i_counts_per_revolution;
                        quotient  <= '0;
                        rem       <= '0;
                        div_bit   <= 6'h20;
                        spd_state <= qrs_pkg::QRS_SPD_DIVIDE;
                    end
                qrs_pkg::QRS_SPD_DIVIDE:
                begin
                    dividend <= {dividend[30:0], 1'b0};
                    if (!rem_trial[32])
                    begin
                        rem      <= rem_trial[31:0];
                        quotient <= {quotient[30:0], 1'b1};
                    end
                    else
                    begin
                        rem      <= {rem[30:0], dividend[31]};
                        quotient <= {quotient[30:0], 1'b0};
                    end
                    div_bit <= div_bit - 6'h1;
                    if (div_bit == 6'h1)
                        spd_state <= qrs_pkg::QRS_SPD_DONE;
                end
                qrs_pkg::QRS_SPD_DONE:
                    spd_state <= qrs_pkg::QRS_SPD_IDLE;
                default:
                    spd_state <= qrs_pkg::QRS_SPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_revolutions_per_minute <= '0;
            o_speed_valid            <= 1'b0;
        end
        else
        begin
            o_speed_valid <= (spd_state == qrs_pkg::QRS_SPD_DONE);
            if (spd_state == qrs_pkg::QRS_SPD_DONE)
                o_revolutions_per_minute <= neg ? -$signed(quotient)
                                                : $signed(quotient);
        end
    end

    // ------------------------------------------------------------
    // Revolution sensor
    // ------------------------------------------------------------
    // Reset value high matches the pulled-up idle input, so with default polarity no event
    // appears at release with a disconnected sensor.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            rev_sync <= 2'h3;
        else
            rev_sync <= {rev_sync[0], i_rev_sensor};
    end

    assign rev_level = i_rev_invert ? rev_sync[1] : ~rev_sync[1];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rev_prev     <= 1'b0;
            o_rev_active <= 1'b0;
            o_rev_event  <= 1'b0;
        end
        else
        begin
            rev_prev     <= rev_level;
            o_rev_active <= rev_level;
            o_rev_event  <= rev_level && !rev_prev;
        end
    end
endmodule

// File: qrs_chk.sv
// Port assertions for the quadrature and revolution sensor block
`timescale 1ns/1ps
module qrs_chk
#(
    parameter int unsigned POS_W = 32
)
(
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic             i_rev_sensor,
    input wire logic             i_rev_invert,
    input wire logic             i_use_slip_check,
    input wire logic [POS_W-1:0] o_position,
    input wire logic [POS_W-1:0] o_slip_count,
    input wire logic             o_rev_active,
    input wire logic             o_rev_event,
    input wire logic             o_phase_fault
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ----------
    // Checks
    // ----------
    // A clear may drop the count to zero from any value
    property p_step; $changed(o_position) |-> o_position == $past(o_position) + 1'b1
        || o_position == $past(o_position) - 1'b1 || o_position == '0; endproperty
    a_step: assert property (p_step) else $error("position jump");
    property p_fault; o_phase_fault |-> $stable(o_position) && $stable(o_slip_count); endproperty
    a_fault: assert property (p_fault) else $error("fault counted");
    property p_event; o_rev_event |-> o_rev_active && !$past(o_rev_active); endproperty
    a_event: assert property (p_event) else $error("bad event");
    property p_low; (!i_rev_sensor && !i_rev_invert) [*4] |=> o_rev_active; endproperty
    a_low: assert property (p_low) else $error("low not active");
    property p_idle; (i_rev_sensor && !i_rev_invert) [*4] |=> !o_rev_active; endproperty
    a_idle: assert property (p_idle) else $error("idle active");
    property p_inv; (i_rev_sensor && i_rev_invert) [*4] |=> o_rev_active; endproperty
    a_inv: assert property (p_inv) else $error("inverted not active");
    property p_slip; i_use_slip_check && $past(i_use_slip_check, 5) |-> $stable(o_position);
    endproperty
    a_slip: assert property (p_slip) else $error("position moved");
    property p_prim; !i_use_slip_check && !$past(i_use_slip_check, 5)
        |-> $stable(o_slip_count) || o_slip_count == '0; endproperty
    a_prim: assert property (p_prim) else $error("slip moved");
endmodule
bind qrs_top qrs_chk #(.POS_W(POS_W)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_rev_sensor(i_rev_sensor), .i_rev_invert(i_rev_invert),
    .i_use_slip_check(i_use_slip_check), .o_position(o_position),
    .o_slip_count(o_slip_count), .o_rev_active(o_rev_active),
    .o_rev_event(o_rev_event), .o_phase_fault(o_phase_fault));

// File: qrs_enc_model.sv
// Behavioural encoder and revolution sensor on the far side
`timescale 1ns/1ps
module qrs_enc_model
(
    input  wire logic i_clk,
    output logic      o_phase_first,
    output logic      o_phase_second,
    output logic      o_rev_sensor
);
    // Start at 11, the pulled-up idle level, so reset release shows no edge
    logic [1:0] idx = 2'h2;
    // Gray walk 00,01,11,10 on {first,second}: second leads when moving up
    assign o_phase_first  = idx[1];
    assign o_phase_second = idx[1] ^ idx[0];
    // Input is pulled up, so an idle sensor reads high
    initial o_rev_sensor = 1'b1;
    task automatic move(input int n, input bit up, input int gap);
        repeat (n)
        begin
            repeat (gap) @(posedge i_clk);
            @(negedge i_clk);
            idx = up ? idx + 2'h1 : idx - 2'h1;
        end
    endtask
    task automatic both;
        @(negedge i_clk);
        idx = idx + 2'h2;
    endtask
    task automatic rev_pulse(input int len);
        @(negedge i_clk);
        o_rev_sensor = 1'b0;
        repeat (len) @(negedge i_clk);
        o_rev_sensor = 1'b1;
    endtask
endmodule

// File: qrs_top_bench.sv
// Self-checking bench for the quadrature and revolution sensor block
`timescale 1ns/1ps
module qrs_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        inv = 1'b0;
    logic        slip = 1'b0;
    logic        clr = 1'b0;
    logic [31:0] per_rev = 32'h00000004;
    logic [31:0] ep = 32'h00000000;
    logic [31:0] pos, spc, spd;
    logic        pa, pb, rev, sv, ra, re, pf;
    int          fail_count = 0;
    int          compares = 0;
    int          nf = 0, ne = 0, nv = 0, n0;
    always #5 clk = ~clk;
    qrs_enc_model enc (.i_clk(clk), .o_phase_first(pa), .o_phase_second(pb), .o_rev_sensor(rev));
    qrs_top #(.WINDOW_CYCLES(1000)) dut (.i_clk(clk), .i_rst(rst), .i_phase_first(pa),
        .i_phase_second(pb), .i_rev_sensor(rev), .i_rev_invert(inv), .i_use_slip_check(slip),
        .i_pos_clear(clr), .i_counts_per_revolution(per_rev), .o_position(pos),
        .o_slip_count(spc), .o_revolutions_per_minute(spd), .o_speed_valid(sv), .o_rev_active(ra),
        .o_rev_event(re), .o_phase_fault(pf));
    always @(posedge clk)
    begin
        nf <= nf + (pf === 1'b1);
        ne <= ne + (re === 1'b1);
        nv <= nv + (sv === 1'b1);
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wt_sv;
        int k;
        k = 0;
        @(negedge clk);
        while (sv !== 1'b1 && k < 1200)
        begin
            @(negedge clk);
            k++;
        end
    endtask
    task tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------
    // Scenarios
    // ----------
    task t_count;
        enc.move(1, 1'b1, 2);
        wt(2);
        chk(pos, ep, "early");
        wt(1);
        chk(pos, ep + 32'h00000001, "late");
        enc.move(11, 1'b1, 2);
        enc.move(20, 1'b0, 2);
        ep = ep - 32'h00000008;
        wt(6);
        chk(pos, ep, "wrap");
        $display("test count done");
    endtask
    task t_fault;
        n0 = nf;
        enc.both;
        wt(8);
        chk(nf - n0, 1, "fault");
        chk(pos, ep, "fault count");
        $display("test fault done");
    endtask
    task t_slip;
        slip = 1'b1;
        wt(50);
        n0 = nv;
        enc.move(8, 1'b1, 2);
        wt(6);
        chk(spc, 32'h00000008, "slip count");
        chk(pos, ep, "frozen");
        wt(1100);
        chk(nv - n0, 0, "slip speed");
        slip = 1'b0;
        $display("test slip done");
    endtask
    // Edges 125 cycles apart are the 200 kHz phase limit: 8 counts per window
    task t_speed;
        fork
            enc.move(48, 1'b1, 125);
            begin
                wt_sv;
                wt_sv;
                wt_sv;
                chk(spd, 32'h000004b0, "speed");
            end
        join
        ep = ep + 32'h00000030;
        wt(6);
        chk(pos, ep, "fast count");
        // Zero counts per revolution is taken as one: -8 counts per window gives -4800
        per_rev = 32'h00000000;
        fork
            enc.move(32, 1'b0, 125);
            begin
                wt_sv;
                wt_sv;
                wt_sv;
                chk(spd, 32'hffffed40, "reverse speed");
            end
        join
        ep = ep - 32'h00000020;
        wt(6);
        chk(pos, ep, "reverse count");
        clr = 1'b1;
        wt(1);
        clr = 1'b0;
        wt(4);
        chk(pos, 0, "clear");
        chk(spc, 0, "clear slip");
        $display("test speed done");
    endtask
    task t_rev;
        n0 = ne;
        fork
            enc.rev_pulse(8);
            begin
                wt(6);
                chk(ra, 1, "low");
            end
        join
        wt(6);
        chk(ne - n0, 1, "event");
        chk(ra, 0, "idle");
        inv = 1'b1;
        wt(6);
        chk(ra, 1, "inverted");
        inv = 1'b0;
        wt(6);
        n0 = ne;
        wt(40);
        chk(ne - n0, 0, "idle event");
        $display("test rev done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        wt(2);
        t_count;
        t_fault;
        t_slip;
        t_speed;
        t_rev;
        tally_and_finish;
    end
    initial
    begin
        #200000;
        fail_count++;
        $display("Error at %0t: watchdog", $time);
        tally_and_finish;
    end
endmodule
